// [stc_clock_tree.sv]
// file: system clock tree control, source selection and prescaled enables
`default_nettype none
// Function
// - Four sources exist: fast and slow internal, fast and slow external oscillators.
// - The fast external oscillator spans 4 to 16 MHz and the fast internal one runs at 8 MHz.
// - The system clock comes from a fast source directly or from the multiplier.
// - A system clock above 72 MHz is refused.
// - Bus, peripheral, timer and converter clocks each have their own prescaler.
// - The chosen slow source feeds the calendar timer and the watchdog.
// - Both USB controllers take the multiplier output through one divider.
// - Wake-up from low power moves the system clock to the fast internal oscillator.
module stc_clock_tree #(
    parameter int DIV_W = stc_pkg::DIV_W
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // oscillator status
    input wire logic I_FAST_INT_RDY,
    input wire logic I_FAST_EXT_RDY,
    input wire logic I_SLOW_INT_RDY,
    input wire logic I_SLOW_EXT_RDY,
    input wire logic I_MULT_LOCK,
    input wire logic [7:0] I_FAST_EXT_MHZ,
    // configuration
    input wire logic [1:0] I_SRC_SEL,
    input wire logic I_SLOW_SEL_EXT,
    input wire logic I_MULT_EN,
    input wire logic I_MULT_FROM_EXT,
    input wire logic [stc_pkg::MUL_W-1:0] I_MULT_FACTOR,
    input wire logic [DIV_W-1:0] I_AHB_DIV,
    input wire logic [DIV_W-1:0] I_APB1_DIV,
    input wire logic [DIV_W-1:0] I_APB2_DIV,
    input wire logic [DIV_W-1:0] I_TIM_DIV,
    input wire logic [DIV_W-1:0] I_ADC_DIV,
    input wire logic [DIV_W-1:0] I_USB_DIV,
    input wire logic I_WAKEUP,
    // oscillator controls
    output logic O_FAST_INT_EN,
    output logic O_FAST_EXT_EN,
    output logic O_MULT_EN,
    output logic [stc_pkg::MUL_W-1:0] O_MULT_FACTOR,
    output logic O_MULT_FROM_EXT,
    // selection state
    output logic [1:0] O_SRC_ACTIVE,
    output logic O_SWITCH_BUSY,
    output logic O_SRC_REFUSED,
    output logic O_FAST_EXT_OUT_OF_RANGE,
    output logic [1:0] O_SLOW_SRC,
    output logic O_SLOW_CLK_VALID,
    // domain enables
    output logic O_AHB_TICK,
    output logic O_APB1_TICK,
    output logic O_APB2_TICK,
    output logic O_TIM_TICK,
    output logic O_ADC_TICK,
    output logic O_USB_DEV_TICK,
    output logic O_USB_HOSTDEV_TICK
);
    localparam int NDIV = 6;

    stc_pkg::stc_src_t active, next_active, pending, next_pending;
    stc_pkg::stc_sw_state_t state, next_state;
    logic [1:0] settle, next_settle;
    logic refused, next_refused;
    logic mult_en, next_mult_en;
    logic [stc_pkg::MUL_W-1:0] factor, next_factor;
    logic from_ext, next_from_ext;
    logic [DIV_W-1:0] divs [NDIV];
    logic [NDIV-1:0] ticks;
    logic [NDIV-1:0] dens;
    logic [12:0] mult_mhz; // wide enough for any input code times 17, so no wrap hides an overspeed
    logic req_ok;
    stc_pkg::stc_src_t req;

    // refuse widths the prescalers cannot serve, at elaboration
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
        $error("stc_clock_tree divider width out of range");
    end

    // source readiness lookup
    function automatic logic src_ready(input stc_pkg::stc_src_t s, input logic fi, input logic fe,
                                       input logic ml);
        case (s)
            stc_pkg::STC_SRC_FAST_INT: src_ready = fi;
            stc_pkg::STC_SRC_FAST_EXT: src_ready = fe;
            stc_pkg::STC_SRC_MULT: src_ready = ml;
            default: src_ready = 1'b0;
        endcase
    endfunction

    // multiplier output frequency: input times (factor+2)
    assign mult_mhz = (from_ext ? {5'h0, I_FAST_EXT_MHZ} : 13'(stc_pkg::FAST_INT_MHZ))
                      * (13'(factor) + 13'h2);
    assign req = (I_SRC_SEL == 2'h1) ? stc_pkg::STC_SRC_FAST_EXT :
                 (I_SRC_SEL == 2'h2) ? stc_pkg::STC_SRC_MULT : stc_pkg::STC_SRC_FAST_INT;
    // fast int is 8 MHz; external and multiplier checked against limits
    assign req_ok = (req != stc_pkg::STC_SRC_MULT) ? (req != stc_pkg::STC_SRC_FAST_EXT
                    || !O_FAST_EXT_OUT_OF_RANGE)
                    : (mult_en && mult_mhz <= 13'(stc_pkg::SYS_MAX_MHZ));

    // switch sequencer next state
    always_comb begin
        next_state = state;
        next_active = active;
        next_pending = pending;
        next_settle = settle;
        next_refused = refused;
        next_mult_en = I_MULT_EN;
        next_factor = mult_en ? factor : I_MULT_FACTOR; // factor only changes while off
        next_from_ext = mult_en ? from_ext : I_MULT_FROM_EXT;
        if (I_WAKEUP) begin
            next_state = stc_pkg::STC_RUN;
            next_active = stc_pkg::STC_SRC_FAST_INT;
            next_pending = stc_pkg::STC_SRC_FAST_INT;
            next_settle = 2'h0;
        end else begin
            case (state)
                stc_pkg::STC_RUN: begin
                    if (req != active) begin
                        next_refused = !req_ok;
                        if (req_ok) begin
                            next_pending = req;
                            next_settle = 2'h0;
                            next_state = stc_pkg::STC_WAIT_STABLE;
                        end
                    end else begin
                        next_refused = 1'b0;
                    end
                end
                stc_pkg::STC_WAIT_STABLE: begin
                    // old source stays live; stability must hold for several edges
                    if (!src_ready(pending, I_FAST_INT_RDY, I_FAST_EXT_RDY, I_MULT_LOCK)) begin
                        next_settle = 2'h0;
                    end else if (settle == stc_pkg::SETTLE_LAST) begin
                        next_state = stc_pkg::STC_HANDOVER;
                    end else begin
                        next_settle = settle + 2'h1;
                    end
                    if (req != pending) begin
                        next_state = stc_pkg::STC_RUN; // request withdrawn
                    end
                end
                stc_pkg::STC_HANDOVER: begin
                    // hand over only at an AHB tick so no domain sees a short period
                    if (O_AHB_TICK) begin
                        next_active = pending;
                        next_state = stc_pkg::STC_RUN;
                    end
                end
                default: next_state = stc_pkg::STC_RUN;
            endcase
        end
        // never drop the multiplier while it drives, or is about to drive, the system clock
        if (next_active == stc_pkg::STC_SRC_MULT
            || (next_state != stc_pkg::STC_RUN && next_pending == stc_pkg::STC_SRC_MULT)) begin
            next_mult_en = 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state <= stc_pkg::STC_RUN;
            active <= stc_pkg::STC_SRC_FAST_INT;
            pending <= stc_pkg::STC_SRC_FAST_INT;
            settle <= 2'h0;
            refused <= 1'b0;
            mult_en <= 1'b0;
            factor <= stc_pkg::MUL_RESET;
            from_ext <= 1'b0;
        end else begin
            state <= next_state;
            active <= next_active;
            pending <= next_pending;
            settle <= next_settle;
            refused <= next_refused;
            mult_en <= next_mult_en;
            factor <= next_factor;
            from_ext <= next_from_ext;
        end
    end

    // prescaler settings come straight from the inputs; divider reset only clears count and tick
    assign divs[0] = I_AHB_DIV;
    assign divs[1] = I_APB1_DIV;
    assign divs[2] = I_APB2_DIV;
    assign divs[3] = I_TIM_DIV;
    assign divs[4] = I_ADC_DIV;
    assign divs[5] = I_USB_DIV;
    assign dens = {mult_en && I_MULT_LOCK, 5'h1f};

    // one prescaler per domain
    for (genvar g = 0; g < NDIV; g++) begin : g_div
        stc_divider #(.W(DIV_W)) u_div (
            .i_clk(I_CLK_SYS),
            .i_reset_n(I_RESET_N),
            .i_div(divs[g]),
            .i_enable(dens[g]),
            .o_tick(ticks[g])
        );
    end

    // domain enables and usb pair share one divider
    assign O_AHB_TICK = ticks[0];
    assign O_APB1_TICK = ticks[1];
    assign O_APB2_TICK = ticks[2];
    assign O_TIM_TICK = ticks[3];
    assign O_ADC_TICK = ticks[4];
    assign O_USB_DEV_TICK = ticks[5];
    assign O_USB_HOSTDEV_TICK = ticks[5];

    // oscillator controls; fast internal stays on while it or a fallback may be needed
    assign O_FAST_INT_EN = 1'b1;
    assign O_FAST_EXT_EN = (active == stc_pkg::STC_SRC_FAST_EXT) || (pending == stc_pkg::STC_SRC_FAST_EXT)
                           || (mult_en && from_ext);
    assign O_MULT_EN = mult_en;
    assign O_MULT_FACTOR = factor;
    assign O_MULT_FROM_EXT = from_ext;
    assign O_SRC_ACTIVE = active;
    assign O_SWITCH_BUSY = (state != stc_pkg::STC_RUN);
    assign O_SRC_REFUSED = refused;
    assign O_FAST_EXT_OUT_OF_RANGE = (I_FAST_EXT_MHZ < 8'(stc_pkg::FAST_EXT_MIN_MHZ))
                                     || (I_FAST_EXT_MHZ > 8'(stc_pkg::FAST_EXT_MAX_MHZ));
    // slow source: 0 internal, 1 external
    assign O_SLOW_SRC = I_SLOW_SEL_EXT ? 2'h1 : 2'h0;
    assign O_SLOW_CLK_VALID = I_SLOW_SEL_EXT ? I_SLOW_EXT_RDY : I_SLOW_INT_RDY;
endmodule
`default_nettype wire

// [stc_pkg.sv]
// package: constants and types for the system clock tree control block
`default_nettype none
package stc_pkg;
    // number of clock sources
    localparam int NUM_SOURCES = 4;
    // oscillator and limit frequencies in MHz
    localparam int FAST_EXT_MIN_MHZ = 4;
    localparam int FAST_EXT_MAX_MHZ = 16;
    localparam int FAST_INT_MHZ = 8;
    localparam int SYS_MAX_MHZ = 72;
    localparam int USB_SYS_A_MHZ = 48;
    localparam int USB_SYS_B_MHZ = 72;
    localparam int ADC_APB2_A_MHZ = 14;
    localparam int ADC_APB2_B_MHZ = 28;
    localparam int ADC_APB2_C_MHZ = 56;
    // prescaler field width and reset value (divide by one)
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_RESET = 4'h0;
    // multiplier factor field width and reset value
    localparam int MUL_W = 4;
    localparam logic [3:0] MUL_RESET = 4'h0;
    // edges of the new source seen before a switch completes
    localparam int SETTLE_EDGES = 3;
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // system clock source choice
    typedef enum logic [1:0] {
        STC_SRC_FAST_INT,
        STC_SRC_FAST_EXT,
        STC_SRC_MULT
    } stc_src_t;

    // switch sequencer states
    typedef enum logic [1:0] {
        STC_RUN,
        STC_WAIT_STABLE,
        STC_HANDOVER
    } stc_sw_state_t;
endpackage
`default_nettype wire

// [stc_divider.sv]
// file: programmable clock-enable divider
`default_nettype none
module stc_divider #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // control
    input wire logic [W-1:0] i_div,
    input wire logic i_enable,
    // output tick
    output logic o_tick
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_tick;

    // refuse widths the counter cannot serve, at elaboration
    if (W < 1 || W > 16) begin : g_bad_width
        $error("stc_divider width out of range");
    end

    // divide by i_div+1; zero means every cycle
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!i_enable) begin
            next_count = '0;
        end else if (count >= i_div) begin
            next_count = '0;
            next_tick = 1'b1;
        end else begin
            next_count = count + W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
            o_tick <= 1'b0;
        end else begin
            count <= next_count;
            o_tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// [stc_clock_tree_asserts.sv]
// checker: port-level assertions for the clock tree control block
`default_nettype none
module stc_clock_tree_asserts #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // watched inputs
    input wire logic I_FAST_EXT_RDY,
    input wire logic I_MULT_LOCK,
    input wire logic [7:0] I_FAST_EXT_MHZ,
    input wire logic [DIV_W-1:0] I_AHB_DIV,
    input wire logic I_WAKEUP,
    // watched outputs
    input wire logic [1:0] O_SRC_ACTIVE,
    input wire logic O_SWITCH_BUSY,
    input wire logic O_FAST_EXT_OUT_OF_RANGE,
    input wire logic O_AHB_TICK,
    input wire logic O_USB_DEV_TICK,
    input wire logic O_USB_HOSTDEV_TICK
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    // switch start, then a settle window with no wake-up override
    sequence s_start;
        $rose(O_SWITCH_BUSY);
    endsequence
    sequence s_calm;
        !I_WAKEUP [*4];
    endsequence
    a_usb_ticks_same: assert property (O_USB_DEV_TICK == O_USB_HOSTDEV_TICK)
        else $error("usb ticks differ");
    a_src_legal: assert property (O_SRC_ACTIVE != 2'h3)
        else $error("illegal active source");
    a_wake_to_int: assert property (I_WAKEUP |=> O_SRC_ACTIVE == 2'h0)
        else $error("wake-up did not select fast internal");
    a_ext_needs_rdy: assert property ($changed(O_SRC_ACTIVE) && O_SRC_ACTIVE == 2'h1 |-> $past(I_FAST_EXT_RDY))
        else $error("switched to external osc while not ready");
    a_mult_needs_lock: assert property ($changed(O_SRC_ACTIVE) && O_SRC_ACTIVE == 2'h2 |-> $past(I_MULT_LOCK))
        else $error("switched to multiplier while unlocked");
    a_switch_via_busy: assert property ($changed(O_SRC_ACTIVE) && !$past(I_WAKEUP) |-> $past(O_SWITCH_BUSY))
        else $error("source changed without a switch sequence");
    a_range_flag: assert property (O_FAST_EXT_OUT_OF_RANGE == (I_FAST_EXT_MHZ < 8'h04 || I_FAST_EXT_MHZ > 8'h10))
        else $error("external osc range flag wrong");
    a_settle_hold: assert property (s_start ##0 s_calm |-> O_SRC_ACTIVE == $past(O_SRC_ACTIVE, 3))
        else $error("source handed over before settling");
    a_ahb_div_one: assert property ((~|I_AHB_DIV) [*3] |-> O_AHB_TICK)
        else $error("bus tick missing at divide by one");
endmodule
bind stc_clock_tree stc_clock_tree_asserts #(.DIV_W(DIV_W)) u_asserts (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_FAST_EXT_RDY(I_FAST_EXT_RDY), .I_MULT_LOCK(I_MULT_LOCK),
    .I_FAST_EXT_MHZ(I_FAST_EXT_MHZ), .I_AHB_DIV(I_AHB_DIV), .I_WAKEUP(I_WAKEUP), .O_SRC_ACTIVE(O_SRC_ACTIVE),
    .O_SWITCH_BUSY(O_SWITCH_BUSY), .O_FAST_EXT_OUT_OF_RANGE(O_FAST_EXT_OUT_OF_RANGE), .O_AHB_TICK(O_AHB_TICK),
    .O_USB_DEV_TICK(O_USB_DEV_TICK), .O_USB_HOSTDEV_TICK(O_USB_HOSTDEV_TICK));
`default_nettype wire

// [stc_testbench.sv]
// testbench: directed scenarios for the clock tree control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n, int_rdy, ext_rdy, sint_rdy, sext_rdy, lock, slow_ext, mult_en, mult_ext, wake;
    logic [7:0] ext_mhz;
    logic [1:0] sel;
    logic [3:0] factor;
    logic [3:0] dv [6];
    wire logic int_en, ext_en, o_mult_en, o_mult_ext, busy, refused, oor, slow_ok;
    wire logic [3:0] o_factor;
    wire logic [1:0] src, slow_src;
    wire logic [6:0] tk;
    int mismatches = 0;
    int checks = 0;
    // 40 MHz system clock
    always #12.5 clk = ~clk;
    stc_clock_tree uut (
        .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_FAST_INT_RDY(int_rdy), .I_FAST_EXT_RDY(ext_rdy),
        .I_SLOW_INT_RDY(sint_rdy), .I_SLOW_EXT_RDY(sext_rdy), .I_MULT_LOCK(lock), .I_FAST_EXT_MHZ(ext_mhz),
        .I_SRC_SEL(sel), .I_SLOW_SEL_EXT(slow_ext), .I_MULT_EN(mult_en), .I_MULT_FROM_EXT(mult_ext),
        .I_MULT_FACTOR(factor), .I_AHB_DIV(dv[0]), .I_APB1_DIV(dv[1]), .I_APB2_DIV(dv[2]), .I_TIM_DIV(dv[3]),
        .I_ADC_DIV(dv[4]), .I_USB_DIV(dv[5]), .I_WAKEUP(wake), .O_FAST_INT_EN(int_en), .O_FAST_EXT_EN(ext_en),
        .O_MULT_EN(o_mult_en), .O_MULT_FACTOR(o_factor), .O_MULT_FROM_EXT(o_mult_ext), .O_SRC_ACTIVE(src),
        .O_SWITCH_BUSY(busy), .O_SRC_REFUSED(refused), .O_FAST_EXT_OUT_OF_RANGE(oor), .O_SLOW_SRC(slow_src),
        .O_SLOW_CLK_VALID(slow_ok), .O_AHB_TICK(tk[0]), .O_APB1_TICK(tk[1]), .O_APB2_TICK(tk[2]),
        .O_TIM_TICK(tk[3]), .O_ADC_TICK(tk[4]), .O_USB_DEV_TICK(tk[5]), .O_USB_HOSTDEV_TICK(tk[6]));
    // value compare, four-state exact
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait: a stuck switch shows as a mismatch, not a hang
    task automatic wait_src(input logic [1:0] e);
        int n;
        n = 0;
        while (src !== e && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("src_active", {6'h0, e}, {6'h0, src});
    endtask
    task automatic finish_test;
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // counts over 24 cycles, a common multiple of all chosen periods; usb divider needs the multiplier on
    task automatic t_divs;
        int c [7];
        dv = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h5, 4'h7};
        c = '{0, 0, 0, 0, 0, 0, 0};
        factor = 4'h4;
        mult_en = 1'b1;
        cyc(16);
        repeat (24) begin
            @(negedge clk);
            for (int j = 0; j < 7; j++) c[j] += int'(tk[j]);
        end
        for (int j = 0; j < 7; j++) chk("tick_count", 8'(24 / (dv[(j < 6) ? j : 5] + 1)), 8'(c[j]));
        dv = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
        mult_en = 1'b0;
    endtask
    task automatic t_ext;
        ext_mhz = 8'h14;
        cyc(1);
        chk("out_of_range", 8'h01, {7'h0, oor});
        sel = 2'h1;
        cyc(12);
        chk("refused", 8'h01, {7'h0, refused});
        chk("src_active", 8'h00, {6'h0, src});
        ext_rdy = 1'b0;
        ext_mhz = 8'h08;
        cyc(12);
        chk("busy", 8'h01, {7'h0, busy});
        chk("src_active", 8'h00, {6'h0, src});
        ext_rdy = 1'b1;
        wait_src(2'h1);
        chk("ext_en", 8'h01, {7'h0, ext_en});
    endtask
    // external 8 MHz times (f+2): factor 8 gives 80 MHz, factor 7 gives 72 MHz, a legal usb setting
    task automatic t_mult;
        sel = 2'h0;
        wait_src(2'h0);
        factor = 4'h8;
        mult_ext = 1'b1;
        mult_en = 1'b1;
        cyc(4);
        sel = 2'h2;
        cyc(12);
        chk("refused", 8'h01, {7'h0, refused});
        chk("src_active", 8'h00, {6'h0, src});
        mult_en = 1'b0;
        cyc(4);
        factor = 4'h7;
        mult_en = 1'b1;
        cyc(4);
        chk("mult_factor", 8'h07, {4'h0, o_factor});
        wait_src(2'h2);
        cyc(1);
        chk("mult_from_ext", 8'h01, {7'h0, o_mult_ext});
        chk("ext_en", 8'h01, {7'h0, ext_en});
        chk("usb_dev_tick", 8'h01, {7'h0, tk[5]});
        chk("usb_hostdev_tick", 8'h01, {7'h0, tk[6]});
    endtask
    task automatic t_wake;
        sel = 2'h0;
        wake = 1'b1;
        cyc(1);
        wake = 1'b0;
        chk("src_active", 8'h00, {6'h0, src});
    endtask
    task automatic t_slow;
        logic [1:0] s0;
        sext_rdy = 1'b0;
        cyc(1);
        chk("slow_valid", 8'h01, {7'h0, slow_ok});
        s0 = slow_src;
        slow_ext = 1'b1;
        cyc(1);
        chk("slow_valid", 8'h00, {7'h0, slow_ok});
        chk("slow_src_moved", 8'h01, {7'h0, slow_src !== s0});
        sext_rdy = 1'b1;
        cyc(1);
        chk("slow_valid", 8'h01, {7'h0, slow_ok});
    endtask
    task automatic t_midrst;
        sel = 2'h2;
        wait_src(2'h2);
        rst_n = 1'b0;
        cyc(2);
        chk("src_active", 8'h00, {6'h0, src});
        chk("mult_en", 8'h00, {7'h0, o_mult_en});
        sel = 2'h0;
        mult_en = 1'b0;
        rst_n = 1'b1;
        cyc(3);
        chk("ahb_tick", 8'h01, {7'h0, tk[0]});
        // int_en is held high all run, as flash erase or program would need
        chk("fast_int_en", 8'h01, {7'h0, int_en});
    endtask
    // main sequence, inputs change on the falling edge only
    initial begin
        {rst_n, ext_rdy, sext_rdy, lock, slow_ext, mult_en, mult_ext, wake} = 8'h00;
        {int_rdy, sint_rdy, lock, ext_mhz, sel, factor} = {3'h7, 8'h08, 2'h0, 4'h0};
        dv = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
        cyc(11);
        chk("src_active", 8'h00, {6'h0, src});
        chk("ticks", 8'h00, {1'h0, tk});
        chk("mult_en", 8'h00, {7'h0, o_mult_en});
        cyc(1);
        rst_n = 1'b1;
        t_divs();
        t_ext();
        t_mult();
        t_wake();
        t_slow();
        t_midrst();
        finish_test();
    end
    // watchdog sized well beyond the directed sequence
    initial begin
        cyc(4000);
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
